// File: ict_timing_seq.sv
// instruction cycle timing sequencer: counts clocks and paces bus reads and writes
// Overview of operation
// - each entry is clocks/reads/writes; plus adds address
// - standard counts include operate, write back, prefetch
// - sum/diff/conj/disj: data 4/6, memory 8/12
// - long register destination base 8 for direct source
// - pointer sum/diff 8/6, pointer compare 6, compare 4/6
// - exclusive disjunction to data: data source only, 4/8
// - divides at most 158 and 140 plus address
// - multiplies take 38+2n, at most 70, one read
// - unsigned multiply n counts source one bits
// - signed multiply n counts 17-bit bit transitions
// - multiply/divide maxima added to word address time
// - immediate sum/diff/disj: 8,16 register; 12,20 memory
// - immediate conj 8/14, immediate compare 8/14, 8/12
// - quick forms 4/8, pointer quick diff 8, load 4
// - single operand 4/6 register, 8/12 memory; decimal 6/8
// - set cond 4/6/8, test-set 4/14, test 4
// - shifts 6+2n / 8+2n register, memory word 8
// - bit ops on register 8,8,10,6 or 12,12,14,10
// - bit ops on memory byte 8/12, test 4/8
// - jumps 10, not taken 8/12, call 18
// - loop jump 12 true, 10 branch, 14 expired
module ict_timing_seq
  import ict_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic            start,
  input  wire ict_op_t         opCode,
  input  wire ict_size_t       opSize,
  input  wire ict_dst_t        opDest,
  input  wire logic            srcDirect,
  input  wire logic            srcDataReg,
  input  wire logic            bitImmediate,
  input  wire logic            condTrue,
  input  wire logic            wordDisp,
  input  wire logic            counterExpired,
  input  wire logic [15:0]     srcValue,
  input  wire logic [5:0]      shiftCount,
  input  wire logic [7:0]      eaClocks,
  input  wire logic [3:0]      eaReads,
  input  wire logic [3:0]      eaWrites,
  output logic                 busy,
  output logic                 busRead,
  output logic                 busWrite,
  output logic                 done,
  output logic                 rejected,
  output logic [CW-1:0]        totalClocks,
  output logic [3:0]           totalReads,
  output logic [3:0]           totalWrites
);

  ict_state_t    state_r;
  logic [CW-1:0] cycle_r;
  logic [CW-1:0] total_r;
  logic [3:0]    reads_r;
  logic [3:0]    writes_r;
  logic          done_r;
  logic          rejected_r;

  logic [CW-1:0] baseClk;
  logic [3:0]    baseRd;
  logic [3:0]    baseWr;
  logic          addEa;
  logic          illegal;

  wire logic          isLong    = (opSize == SZ_LONG);
  wire logic          isByte    = (opSize == SZ_BYTE);
  wire logic          toMem     = (opDest == DST_MEM);
  wire logic          toPtr     = (opDest == DST_PTR);
  wire logic          toData    = (opDest == DST_DATA);
  wire logic          badDest   = (opDest == 2'h3);
  wire logic [CW-1:0] longReg   = srcDirect ? T_REG_L_DIRECT : T_REG_L;
  wire logic [CW-1:0] shiftAdd  = {2'h0, shiftCount, 1'b0};
  wire logic [16:0]   signedExt = {srcValue, 1'b0};

  function automatic logic [4:0] ones16(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  wire logic [4:0]    umulN   = ones16(srcValue);
  wire logic [4:0]    smulN   = ones16(signedExt[16:1] ^ signedExt[15:0]);
  wire logic [4:0]    mulN    = (opCode == OPC_SMUL) ? smulN : umulN;
  wire logic [CW-1:0] mulClk  = T_MUL_BASE + {3'h0, mulN, 1'b0};

  // timing table: base triple and whether the address triple is added
  always_comb begin
    baseClk = T_REG_BW;
    baseRd  = 4'h1;
    baseWr  = 4'h0;
    addEa   = 1'b0;
    illegal = badDest;
    unique case (opCode)
      OPC_SUM, OPC_DIFFERENCE, OPC_CONJ, OPC_DISJ: begin
        addEa = 1'b1;
        if (toMem) begin
          baseClk = isLong ? T_MEM_L : T_MEM_BW;
          baseWr  = isLong ? 4'h2 : 4'h1;
        end else if (toPtr) begin
          illegal = isByte || (opCode == OPC_CONJ) || (opCode == OPC_DISJ);
          baseClk = isLong ? longReg : T_PTR_W;
        end else begin
          baseClk = isLong ? longReg : T_REG_BW;
        end
      end
      OPC_COMPARE: begin
        addEa   = 1'b1;
        illegal = toMem || (toPtr && isByte);
        baseClk = toPtr ? T_CMP_PTR : (isLong ? T_REG_L : T_REG_BW);
      end
      OPC_XDISJ: begin
        if (toMem) begin
          addEa   = 1'b1;
          baseClk = isLong ? T_MEM_L : T_MEM_BW;
          baseWr  = isLong ? 4'h2 : 4'h1;
        end else begin
          illegal = toPtr || !srcDataReg;
          baseClk = isLong ? T_XDISJ_L : T_REG_BW;
        end
      end
      OPC_SDIV, OPC_UDIV, OPC_SMUL, OPC_UMUL: begin
        addEa   = 1'b1;
        illegal = !toData;
        if (opCode == OPC_SDIV) begin
          baseClk = T_SDIV_MAX;
        end else if (opCode == OPC_UDIV) begin
          baseClk = T_UDIV_MAX;
        end else begin
          baseClk = mulClk;
        end
      end
      OPC_SUM_IMM, OPC_DIFF_IMM, OPC_DISJ_IMM, OPC_XDISJ_IMM, OPC_CONJ_IMM: begin
        illegal = toPtr;
        baseRd  = isLong ? 4'h3 : 4'h2;
        if (toMem) begin
          addEa   = 1'b1;
          baseClk = isLong ? T_IMM_MEM_L : T_IMM_MEM_BW;
          baseWr  = isLong ? 4'h2 : 4'h1;
        end else if (opCode == OPC_CONJ_IMM) begin
          baseClk = isLong ? T_CONJI_REG_L : T_IMM_REG_BW;
        end else begin
          baseClk = isLong ? T_IMM_REG_L : T_IMM_REG_BW;
        end
      end
      OPC_COMPARE_IMM: begin
        illegal = toPtr;
        addEa   = toMem;
        baseRd  = isLong ? 4'h3 : 4'h2;
        if (toMem) begin
          baseClk = isLong ? T_COMPARE_IMMEDIATE_OP_MEM_L : T_COMPARE_IMMEDIATE_OP_MEM_BW;
        end else begin
          baseClk = isLong ? T_CONJI_REG_L : T_IMM_REG_BW;
        end
      end
      OPC_QSUM, OPC_QDIFF: begin
        if (toMem) begin
          addEa   = 1'b1;
          baseClk = isLong ? T_MEM_L : T_MEM_BW;
          baseWr  = isLong ? 4'h2 : 4'h1;
        end else if (toPtr && !isLong) begin
          illegal = isByte;
          baseClk = (opCode == OPC_QDIFF) ? T_QDIFF_PTR_W : T_QUICK_BW;
        end else begin
          baseClk = isLong ? T_QUICK_L : T_QUICK_BW;
        end
      end
      OPC_QLOAD: begin
        illegal = !toData || !isLong;
        baseClk = T_QLOAD;
      end
      OPC_ZERO_FILL, OPC_TWOS, OPC_EXT_COMPL, OPC_ONES: begin
        illegal = toPtr;
        addEa   = toMem;
        if (toMem) begin
          baseClk = isLong ? T_MEM_L : T_MEM_BW;
          baseWr  = isLong ? 4'h2 : 4'h1;
        end else begin
          baseClk = isLong ? T_REG_L : T_REG_BW;
        end
      end
      OPC_DEC_NEG, OPC_SET_COND, OPC_TEST_SET: begin
        illegal = toPtr || !isByte;
        addEa   = toMem;
        baseWr  = {3'h0, toMem};
        if (opCode == OPC_DEC_NEG) begin
          baseClk = toMem ? T_MEM_BW : T_DECNEG_REG;
        end else if (opCode == OPC_SET_COND) begin
          baseClk = toMem ? T_MEM_BW : (condTrue ? T_SETC_TRUE : T_SETC_FALSE);
        end else begin
          baseClk = toMem ? T_TAS_MEM : T_TAS_REG;
          baseRd  = toMem ? 4'h2 : 4'h1;
        end
      end
      OPC_TEST_ZERO: begin
        illegal = toPtr;
        addEa   = toMem;
        baseClk = T_TSTZ;
      end
      OPC_SHIFT: begin
        illegal = toPtr || (toMem && (opSize != SZ_WORD));
        addEa   = toMem;
        baseWr  = {3'h0, toMem};
        if (toMem) begin
          baseClk = T_SHIFT_MEM;
        end else begin
          baseClk = (isLong ? T_SHIFT_L : T_SHIFT_BW) + shiftAdd;
        end
      end
      OPC_BIT_FLIP, OPC_BIT_SET, OPC_BIT_CLEAR, OPC_BIT_TEST: begin
        illegal = toPtr || (toMem ? !isByte : !isLong);
        addEa   = toMem;
        baseRd  = bitImmediate ? 4'h2 : 4'h1;
        if (toMem && opCode == OPC_BIT_TEST) begin
          baseClk = bitImmediate ? T_BMEM_TST_STA : T_BMEM_TST_DYN;
        end else if (toMem) begin
          baseClk = bitImmediate ? T_BMEM_STA : T_BMEM_DYN;
          baseWr  = 4'h1;
        end else if (opCode == OPC_BIT_TEST) begin
          baseClk = bitImmediate ? T_BSTA_TEST : T_BDYN_TEST;
        end else if (opCode == OPC_BIT_CLEAR) begin
          baseClk = bitImmediate ? T_BSTA_CLEAR : T_BDYN_CLEAR;
        end else begin
          baseClk = bitImmediate ? T_BSTA_FLIPSET : T_BDYN_FLIPSET;
        end
      end
      OPC_COND_JUMP: begin
        baseClk = condTrue ? T_JUMP_TAKEN : (wordDisp ? T_NOTTAKEN_W : T_NOTTAKEN_B);
        baseRd  = (condTrue || wordDisp) ? 4'h2 : 4'h1;
      end
      OPC_REL_JUMP: begin
        baseClk = T_JUMP_TAKEN;
        baseRd  = 4'h2;
      end
      OPC_REL_CALL: begin
        baseClk = T_CALL;
        baseRd  = 4'h2;
        baseWr  = 4'h2;
      end
      OPC_LOOP_JUMP: begin
        if (condTrue) begin
          baseClk = T_LOOP_TRUE;
          baseRd  = 4'h2;
        end else if (counterExpired) begin
          baseClk = T_LOOP_EXPIRED;
          baseRd  = 4'h3;
        end else begin
          baseClk = T_LOOP_BRANCH;
          baseRd  = 4'h2;
        end
      end
      default: begin
        illegal = 1'b1;
      end
    endcase
  end

  // component-wise sum with the address calculation triple
  wire logic [CW-1:0] sumClk = baseClk + (addEa ? {1'b0, eaClocks} : 9'h000);
  wire logic [3:0]    sumRd  = baseRd + (addEa ? eaReads : 4'h0);
  wire logic [3:0]    sumWr  = baseWr + (addEa ? eaWrites : 4'h0);

  wire logic          accept   = (state_r == ST_IDLE) && start && !illegal;
  wire logic          refuse   = (state_r == ST_IDLE) && start && illegal;
  wire logic          lastCyc  = (state_r == ST_RUN) && (cycle_r == total_r - 9'h001);
  wire logic [6:0]    slot     = cycle_r[8:2];
  wire logic          slotHead = (cycle_r[1:0] == 2'h0) && (state_r == ST_RUN);
  wire logic [6:0]    rdEnd    = {3'h0, reads_r};
  wire logic [6:0]    wrEnd    = rdEnd + {3'h0, writes_r};

  // each bus cycle takes its nominal four clocks; reads first, then writes
  assign busRead  = slotHead && (slot < rdEnd);
  assign busWrite = slotHead && (slot >= rdEnd) && (slot < wrEnd);
  assign busy     = (state_r == ST_RUN);
  assign done     = done_r;
  assign rejected = rejected_r;

  assign totalClocks = total_r;
  assign totalReads  = reads_r;
  assign totalWrites = writes_r;

  wire ict_state_t    state_nxt = accept ? ST_RUN : (lastCyc ? ST_IDLE : state_r);
  wire logic [CW-1:0] cycle_nxt = (state_r == ST_RUN && !lastCyc) ? cycle_r + 9'h001 : 9'h000;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      cycle_r    <= 9'h000;
      total_r    <= 9'h000;
      reads_r    <= 4'h0;
      writes_r   <= 4'h0;
      done_r     <= 1'b0;
      rejected_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cycle_r    <= cycle_nxt;
      done_r     <= lastCyc;
      rejected_r <= refuse;
      if (accept) begin
        total_r  <= sumClk;
        reads_r  <= sumRd;
        writes_r <= sumWr;
      end
    end
  end

endmodule

// File: ict_pkg.sv
// package of timing constants and encodings for the instruction cycle timing sequencer
package ict_pkg;

  localparam int CW = 9;

  localparam logic [CW-1:0] T_BUS_CYCLE    = 9'h004;
  localparam logic [CW-1:0] T_REG_BW       = 9'h004;
  localparam logic [CW-1:0] T_REG_L        = 9'h006;
  localparam logic [CW-1:0] T_REG_L_DIRECT = 9'h008;
  localparam logic [CW-1:0] T_MEM_BW       = 9'h008;
  localparam logic [CW-1:0] T_MEM_L        = 9'h00C;
  localparam logic [CW-1:0] T_PTR_W        = 9'h008;
  localparam logic [CW-1:0] T_CMP_PTR      = 9'h006;
  localparam logic [CW-1:0] T_XDISJ_L      = 9'h008;
  localparam logic [CW-1:0] T_SDIV_MAX     = 9'h09E;
  localparam logic [CW-1:0] T_UDIV_MAX     = 9'h08C;
  localparam logic [CW-1:0] T_MUL_BASE     = 9'h026;
  localparam logic [CW-1:0] T_IMM_REG_BW   = 9'h008;
  localparam logic [CW-1:0] T_IMM_REG_L    = 9'h010;
  localparam logic [CW-1:0] T_IMM_MEM_BW   = 9'h00C;
  localparam logic [CW-1:0] T_IMM_MEM_L    = 9'h014;
  localparam logic [CW-1:0] T_CONJI_REG_L  = 9'h00E;
  localparam logic [CW-1:0] T_COMPARE_IMMEDIATE_OP_MEM_BW  = 9'h008;
  localparam logic [CW-1:0] T_COMPARE_IMMEDIATE_OP_MEM_L   = 9'h00C;
  localparam logic [CW-1:0] T_QUICK_BW     = 9'h004;
  localparam logic [CW-1:0] T_QUICK_L      = 9'h008;
  localparam logic [CW-1:0] T_QDIFF_PTR_W  = 9'h008;
  localparam logic [CW-1:0] T_QLOAD        = 9'h004;
  localparam logic [CW-1:0] T_DECNEG_REG   = 9'h006;
  localparam logic [CW-1:0] T_SETC_FALSE   = 9'h004;
  localparam logic [CW-1:0] T_SETC_TRUE    = 9'h006;
  localparam logic [CW-1:0] T_TAS_REG      = 9'h004;
  localparam logic [CW-1:0] T_TAS_MEM      = 9'h00E;
  localparam logic [CW-1:0] T_TSTZ         = 9'h004;
  localparam logic [CW-1:0] T_SHIFT_BW     = 9'h006;
  localparam logic [CW-1:0] T_SHIFT_L      = 9'h008;
  localparam logic [CW-1:0] T_SHIFT_MEM    = 9'h008;
  localparam logic [CW-1:0] T_BDYN_FLIPSET = 9'h008;
  localparam logic [CW-1:0] T_BDYN_CLEAR   = 9'h00A;
  localparam logic [CW-1:0] T_BDYN_TEST    = 9'h006;
  localparam logic [CW-1:0] T_BSTA_FLIPSET = 9'h00C;
  localparam logic [CW-1:0] T_BSTA_CLEAR   = 9'h00E;
  localparam logic [CW-1:0] T_BSTA_TEST    = 9'h00A;
  localparam logic [CW-1:0] T_BMEM_DYN     = 9'h008;
  localparam logic [CW-1:0] T_BMEM_STA     = 9'h00C;
  localparam logic [CW-1:0] T_BMEM_TST_DYN = 9'h004;
  localparam logic [CW-1:0] T_BMEM_TST_STA = 9'h008;
  localparam logic [CW-1:0] T_JUMP_TAKEN   = 9'h00A;
  localparam logic [CW-1:0] T_NOTTAKEN_B   = 9'h008;
  localparam logic [CW-1:0] T_NOTTAKEN_W   = 9'h00C;
  localparam logic [CW-1:0] T_CALL         = 9'h012;
  localparam logic [CW-1:0] T_LOOP_TRUE    = 9'h00C;
  localparam logic [CW-1:0] T_LOOP_BRANCH  = 9'h00A;
  localparam logic [CW-1:0] T_LOOP_EXPIRED = 9'h00E;

  typedef enum logic [5:0] {
    OPC_SUM         = 6'h00, OPC_DIFFERENCE = 6'h01, OPC_CONJ       = 6'h02,
    OPC_DISJ        = 6'h03, OPC_COMPARE    = 6'h04, OPC_XDISJ      = 6'h05,
    OPC_SDIV        = 6'h06, OPC_UDIV       = 6'h07, OPC_SMUL       = 6'h08,
    OPC_UMUL        = 6'h09, OPC_SUM_IMM    = 6'h0A, OPC_DIFF_IMM   = 6'h0B,
    OPC_CONJ_IMM    = 6'h0C, OPC_DISJ_IMM   = 6'h0D, OPC_XDISJ_IMM  = 6'h0E,
    OPC_COMPARE_IMM = 6'h0F, OPC_QSUM       = 6'h10, OPC_QDIFF      = 6'h11,
    OPC_QLOAD       = 6'h12, OPC_ZERO_FILL  = 6'h13, OPC_TWOS       = 6'h14,
    OPC_EXT_COMPL   = 6'h15, OPC_ONES       = 6'h16, OPC_DEC_NEG    = 6'h17,
    OPC_SET_COND    = 6'h18, OPC_TEST_SET   = 6'h19, OPC_TEST_ZERO  = 6'h1A,
    OPC_SHIFT       = 6'h1B, OPC_BIT_FLIP   = 6'h1C, OPC_BIT_SET    = 6'h1D,
    OPC_BIT_CLEAR   = 6'h1E, OPC_BIT_TEST   = 6'h1F, OPC_COND_JUMP  = 6'h20,
    OPC_REL_JUMP    = 6'h21, OPC_REL_CALL   = 6'h22, OPC_LOOP_JUMP  = 6'h23
  } ict_op_t;

  typedef enum logic [1:0] {
    DST_DATA = 2'h0,
    DST_PTR  = 2'h1,
    DST_MEM  = 2'h2
  } ict_dst_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } ict_size_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } ict_state_t;

endpackage

// File: ict_timing_checker.sv
// port protocol assertions for the instruction cycle timing sequencer
module ict_timing_checker
  import ict_pkg::*;
(
  input wire logic          clock,
  input wire logic          rst,
  input wire logic          start,
  input wire logic          busy,
  input wire logic          busRead,
  input wire logic          busWrite,
  input wire logic          done,
  input wire logic          rejected,
  input wire logic [CW-1:0] totalClocks,
  input wire logic [3:0]    totalReads
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [CW-1:0] busyCnt_r;
  logic          rstSeen_r;
  always_ff @(posedge clock) begin
    busyCnt_r <= (rst || !busy) ? '0 : busyCnt_r + 1'b1;
    rstSeen_r <= rst;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  busy_len_a: assert property ($fell(busy) && !rstSeen_r |-> busyCnt_r == totalClocks)
    else $error("busy length differs from total clocks");
  done_end_a: assert property ($fell(busy) && !rstSeen_r |-> done)
    else $error("done missing after busy");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  rej_idle_a: assert property (rejected |-> $past(start) && !$past(busy) && !busy)
    else $error("rejected without idle start");
  busy_cause_a: assert property ($rose(busy) |-> $past(start))
    else $error("busy rose without start");
  first_read_a: assert property ($rose(busy) && totalReads != 4'h0 |-> busRead)
    else $error("first read missing");
  strobe_busy_a: assert property (busRead || busWrite |-> busy && !(busRead && busWrite))
    else $error("strobe outside busy or both");
  strobe_gap_a: assert property (busRead || busWrite |=> !(busRead || busWrite) [*3])
    else $error("strobes closer than a slot");
  totals_hold_a: assert property (busy && $past(busy) |-> $stable(totalClocks))
    else $error("totals moved while busy");
  cover property (done ##1 busy);
  cover property (rejected);
  cover property (busWrite);
endmodule

bind ict_timing_seq ict_timing_checker ict_timing_checker_inst (
  .clock(clock), .rst(rst), .start(start), .busy(busy), .busRead(busRead),
  .busWrite(busWrite), .done(done), .rejected(rejected),
  .totalClocks(totalClocks), .totalReads(totalReads)
);

// File: ict_bus_model.sv
// memory side model: counts read and write bus cycles of one instruction
module ict_bus_model (
  input  wire logic       clock,
  input  wire logic       busy,
  input  wire logic       busRead,
  input  wire logic       busWrite,
  output logic      [3:0] rdCount,
  output logic      [3:0] wrCount
);
  timeunit 1ns;
  timeprecision 1ps;
  // every bus cycle is answered inside its slot, so no wait is ever added
  always @(posedge clock) begin
    if (!busy) begin
      rdCount <= 4'h0;
      wrCount <= 4'h0;
    end else begin
      rdCount <= rdCount + {3'h0, busRead};
      wrCount <= wrCount + {3'h0, busWrite};
    end
  end
endmodule

// File: tb.sv
// self-checking bench of the instruction cycle timing sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ict_pkg::*;
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  logic          start = 1'b0;
  ict_op_t       opCode = OPC_SUM;
  ict_size_t     opSize = SZ_WORD;
  ict_dst_t      opDest = DST_DATA;
  logic [5:0]    fl = 6'h00;
  logic [15:0]   srcValue = 16'h0000;
  logic [5:0]    shiftCount = 6'h00;
  logic [7:0]    eaClocks = 8'h00;
  logic [3:0]    eaReads = 4'h0;
  logic [3:0]    eaWrites = 4'h0;
  logic          busy, busRead, busWrite, done, rejected;
  logic [CW-1:0] totalClocks;
  logic [3:0]    totalReads, totalWrites, rdCount, wrCount;
  int            n_fail = 0;
  int            total_checks = 0;
  int            cyc = 0;
  ict_op_t       ops[4];

  always #5 clock = ~clock;

  ict_timing_seq ict_timing_seq_inst (.clock(clock), .rst(rst), .start(start), .opCode(opCode),
    .opSize(opSize), .opDest(opDest), .srcDirect(fl[5]), .srcDataReg(fl[4]),
    .bitImmediate(fl[3]), .condTrue(fl[2]), .wordDisp(fl[1]), .counterExpired(fl[0]),
    .srcValue(srcValue), .shiftCount(shiftCount), .eaClocks(eaClocks), .eaReads(eaReads),
    .eaWrites(eaWrites), .busy(busy), .busRead(busRead), .busWrite(busWrite), .done(done),
    .rejected(rejected), .totalClocks(totalClocks), .totalReads(totalReads),
    .totalWrites(totalWrites));
  ict_bus_model ict_bus_model_inst (.clock(clock), .busy(busy), .busRead(busRead),
    .busWrite(busWrite), .rdCount(rdCount), .wrCount(wrCount));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_clk(input logic [CW-1:0] got, input logic [CW-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t clocks got %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t count got %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  // one instruction; also used back to back since it returns in the done cycle
  task automatic go(input ict_op_t o, input ict_size_t s, input ict_dst_t d,
                    input logic [5:0] f, input logic [CW-1:0] c, input logic [3:0] r,
                    input logic [3:0] w);
    logic [CW-1:0] n;
    int            k;
    n = '0;
    k = 0;
    opCode = o;
    opSize = s;
    opDest = d;
    fl = f;
    start = 1'b1;
    @(posedge clock);
    #1 start = 1'b0;
    while (done !== 1'b1 && k < 600) begin
      if (busy === 1'b1) n = n + 1'b1;
      k++;
      @(posedge clock);
      #1;
    end
    // an instruction that never finishes counts as a mismatch
    if (k >= 600) n_fail++;
    chk_clk(n, c);
    chk_clk(totalClocks, c);
    chk_cnt(totalReads, r);
    chk_cnt(rdCount, r);
    chk_cnt(totalWrites, w);
    chk_cnt(wrCount, w);
  endtask

  task automatic rej(input ict_op_t o, input ict_dst_t d, input logic [5:0] f);
    opCode = o;
    opDest = d;
    fl = f;
    start = 1'b1;
    @(posedge clock);
    #1 start = 1'b0;
    chk_flag(rejected, 1'b1);
    chk_flag(busy, 1'b0);
    @(posedge clock);
    #1 chk_flag(rejected, 1'b0);
  endtask

  task automatic t_standard();
    go(OPC_SUM, SZ_WORD, DST_DATA, 6'h00, 9'h004, 4'h1, 4'h0);
    go(OPC_DIFFERENCE, SZ_LONG, DST_DATA, 6'h20, 9'h008, 4'h1, 4'h0);
    go(OPC_CONJ, SZ_LONG, DST_DATA, 6'h00, 9'h006, 4'h1, 4'h0);
    go(OPC_DISJ, SZ_LONG, DST_MEM, 6'h00, 9'h00C, 4'h1, 4'h2);
    go(OPC_SUM, SZ_WORD, DST_PTR, 6'h00, 9'h008, 4'h1, 4'h0);
    go(OPC_COMPARE, SZ_LONG, DST_PTR, 6'h00, 9'h006, 4'h1, 4'h0);
    go(OPC_COMPARE, SZ_LONG, DST_DATA, 6'h00, 9'h006, 4'h1, 4'h0);
    eaClocks = 8'h04;
    eaReads = 4'h1;
    go(OPC_SUM, SZ_BYTE, DST_MEM, 6'h00, 9'h00C, 4'h2, 4'h1);
    go(OPC_XDISJ, SZ_LONG, DST_DATA, 6'h10, 9'h008, 4'h1, 4'h0);
    go(OPC_UDIV, SZ_WORD, DST_DATA, 6'h00, 9'h090, 4'h2, 4'h0);
    go(OPC_SDIV, SZ_WORD, DST_DATA, 6'h00, 9'h0A2, 4'h2, 4'h0);
    eaClocks = 8'h08;
    eaWrites = 4'h1;
    go(OPC_XDISJ, SZ_WORD, DST_MEM, 6'h00, 9'h010, 4'h2, 4'h2);
    eaWrites = 4'h0;
    eaClocks = 8'h00;
    eaReads = 4'h0;
    rej(OPC_XDISJ, DST_DATA, 6'h00);
    rej(OPC_SUM, ict_dst_t'(2'h3), 6'h00);
  endtask

  task automatic t_mul();
    srcValue = 16'hFFFF;
    go(OPC_UMUL, SZ_WORD, DST_DATA, 6'h00, 9'h046, 4'h1, 4'h0);
    go(OPC_SMUL, SZ_WORD, DST_DATA, 6'h00, 9'h028, 4'h1, 4'h0);
    srcValue = 16'h5555;
    go(OPC_SMUL, SZ_WORD, DST_DATA, 6'h00, 9'h046, 4'h1, 4'h0);
    srcValue = 16'h0101;
    go(OPC_UMUL, SZ_WORD, DST_DATA, 6'h00, 9'h02A, 4'h1, 4'h0);
    srcValue = 16'h0000;
    go(OPC_UMUL, SZ_WORD, DST_DATA, 6'h00, 9'h026, 4'h1, 4'h0);
  endtask

  task automatic t_imm_quick();
    ops = '{OPC_SUM_IMM, OPC_DIFF_IMM, OPC_XDISJ_IMM, OPC_DISJ_IMM};
    foreach (ops[i]) go(ops[i], SZ_LONG, DST_DATA, 6'h00, 9'h010, 4'h3, 4'h0);
    go(OPC_DISJ_IMM, SZ_WORD, DST_MEM, 6'h00, 9'h00C, 4'h2, 4'h1);
    go(OPC_CONJ_IMM, SZ_LONG, DST_DATA, 6'h00, 9'h00E, 4'h3, 4'h0);
    go(OPC_COMPARE_IMM, SZ_LONG, DST_MEM, 6'h00, 9'h00C, 4'h3, 4'h0);
    go(OPC_QSUM, SZ_BYTE, DST_DATA, 6'h00, 9'h004, 4'h1, 4'h0);
    go(OPC_QDIFF, SZ_WORD, DST_PTR, 6'h00, 9'h008, 4'h1, 4'h0);
    go(OPC_QSUM, SZ_WORD, DST_PTR, 6'h00, 9'h004, 4'h1, 4'h0);
    go(OPC_QLOAD, SZ_LONG, DST_DATA, 6'h00, 9'h004, 4'h1, 4'h0);
  endtask

  task automatic t_single_shift();
    ops = '{OPC_ZERO_FILL, OPC_TWOS, OPC_EXT_COMPL, OPC_ONES};
    foreach (ops[i]) go(ops[i], SZ_LONG, DST_MEM, 6'h00, 9'h00C, 4'h1, 4'h2);
    go(OPC_DEC_NEG, SZ_BYTE, DST_DATA, 6'h00, 9'h006, 4'h1, 4'h0);
    go(OPC_SET_COND, SZ_BYTE, DST_DATA, 6'h00, 9'h004, 4'h1, 4'h0);
    go(OPC_SET_COND, SZ_BYTE, DST_DATA, 6'h04, 9'h006, 4'h1, 4'h0);
    go(OPC_TEST_SET, SZ_BYTE, DST_MEM, 6'h00, 9'h00E, 4'h2, 4'h1);
    shiftCount = 6'h05;
    go(OPC_SHIFT, SZ_WORD, DST_DATA, 6'h00, 9'h010, 4'h1, 4'h0);
    go(OPC_SHIFT, SZ_WORD, DST_MEM, 6'h00, 9'h008, 4'h1, 4'h1);
  endtask

  task automatic t_bit_branch();
    go(OPC_BIT_CLEAR, SZ_LONG, DST_DATA, 6'h00, 9'h00A, 4'h1, 4'h0);
    go(OPC_BIT_TEST, SZ_LONG, DST_DATA, 6'h08, 9'h00A, 4'h2, 4'h0);
    go(OPC_BIT_SET, SZ_BYTE, DST_MEM, 6'h08, 9'h00C, 4'h2, 4'h1);
    go(OPC_BIT_TEST, SZ_BYTE, DST_MEM, 6'h00, 9'h004, 4'h1, 4'h0);
    go(OPC_COND_JUMP, SZ_WORD, DST_DATA, 6'h04, 9'h00A, 4'h2, 4'h0);
    go(OPC_COND_JUMP, SZ_WORD, DST_DATA, 6'h02, 9'h00C, 4'h2, 4'h0);
    go(OPC_COND_JUMP, SZ_BYTE, DST_DATA, 6'h00, 9'h008, 4'h1, 4'h0);
    go(OPC_REL_JUMP, SZ_WORD, DST_DATA, 6'h00, 9'h00A, 4'h2, 4'h0);
    go(OPC_REL_CALL, SZ_WORD, DST_DATA, 6'h00, 9'h012, 4'h2, 4'h2);
    go(OPC_LOOP_JUMP, SZ_WORD, DST_DATA, 6'h04, 9'h00C, 4'h2, 4'h0);
    go(OPC_LOOP_JUMP, SZ_WORD, DST_DATA, 6'h00, 9'h00A, 4'h2, 4'h0);
    go(OPC_LOOP_JUMP, SZ_WORD, DST_DATA, 6'h01, 9'h00E, 4'h3, 4'h0);
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    chk_flag(busy, 1'b0);
    chk_clk(totalClocks, 9'h000);
    t_standard();
    t_mul();
    t_imm_quick();
    t_single_shift();
    t_bit_branch();
    report_and_stop();
  end
endmodule
